// ### shared/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_SEQ_FORMAT  = 3'h3;
   localparam logic [2:0] OFS_SAMPLE_PRS  = 3'h4;
   localparam logic [2:0] OFS_START       = 3'h5;
   localparam logic [2:0] OFS_STATUS      = 3'h6;
   localparam logic [2:0] OFS_RESULT      = 3'h7;
   localparam int         ADDR_W          = 3;
   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int         JUSTIFY_BIT     = 7;
   localparam int         SEQ_LEN_LSB     = 3;
   localparam int         FREEZE_LSB      = 0;
   localparam int         SMP_LSB         = 5;
   localparam int         PRS_LSB         = 0;
   localparam logic [7:0] SEQ_FORMAT_RST  = 8'h20;
   localparam logic [7:0] SAMPLE_PRS_RST  = 8'h00;
   localparam logic [3:0] SEQ_LEN_MAX     = 4'hC;
   localparam logic [4:0] CONV_CYCLES     = 5'h0A;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FRZ_CONTINUE = 2'h0,
      FRZ_RESERVED = 2'h1,
      FRZ_FINISH   = 2'h2,
      FRZ_NOW      = 2'h3
   } freeze_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;
   typedef struct packed {
      logic [9:0] code;
      logic       ten_bit;
   } analog_t;
endpackage
`default_nettype wire

// ### rtl/conv_clk_div.sv
`default_nettype none
module conv_clk_div (
   input  wire logic       CORE_CLK,
   input  wire logic       RST_N,
   input  wire logic [4:0] prescale,
   input  wire logic       reload,
   output logic            tick
);
   import adc_seq_pkg::*;
   typedef struct packed {
      logic [5:0] cnt;
      logic       tick;
   } div_state_t;
   div_state_t st_reg;
   div_state_t st_next;
   logic [5:0] period_m1;
   always_comb begin
      period_m1 = {prescale, 1'b1};
      st_next   = st_reg;
      st_next.tick = 1'b0;
      if (reload) begin
         st_next.cnt = 6'h00;
      end else if (st_reg.cnt >= period_m1) begin
         st_next.cnt  = 6'h00;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 6'h01;
      end
   end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign tick = st_reg.tick;
endmodule
`default_nettype wire

// ### rtl/adc_seq_ctrl.sv
`default_nettype none
module adc_seq_ctrl (
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST_N,
   input  wire adc_seq_pkg::bus_req_t BUS,
   output logic [7:0]                RDATA,
   input  wire logic                 DEBUG_BREAK,
   input  wire adc_seq_pkg::analog_t ANALOG_IN,
   output logic                      SEQ_ACTIVE,
   output logic                      SAMPLING,
   output logic                      SEQ_DONE,
   output logic [15:0]               RESULT
);
   import adc_seq_pkg::*;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE   = 4'b0001,
      S_SAMPLE = 4'b0010,
      S_CONV   = 4'b0100,
      S_FROZEN = 4'b1000
   } phase_t;
   typedef struct packed {
      phase_t      phase;
      logic [7:0]  fmt;
      logic [7:0]  smp_prs;
      logic [4:0]  phase_cnt;
      logic [3:0]  conv_idx;
      logic        done;
      logic        break_s1;
      logic        break_s2;
      logic [15:0] result;
      logic [7:0]  rdata;
      logic [9:0]  code_s1;
      logic [9:0]  code_s2;
      logic        ten_s1;
      logic        ten_s2;
      logic        active;
      logic        sampling;
   } ctrl_state_t;
   ctrl_state_t st_reg;
   ctrl_state_t st_next;
   logic        tick;
   logic        prs_write;
   logic        abort;
   logic        freeze_now;
   logic        freeze_end;
   logic [3:0]  seq_len;
   logic [4:0]  smp_len;
   // ------------------------------------------------------------
   // Decoders
   // ------------------------------------------------------------
   function automatic logic [3:0] len_decode(input logic [3:0] code);
      if (code == 4'h0 || code > 4'hB) begin
         return SEQ_LEN_MAX;
      end
      return code;
   endfunction
   function automatic logic [4:0] smp_decode(input logic [2:0] code);
      unique case (code)
         3'h0: return 5'h04;
         3'h1: return 5'h06;
         3'h2: return 5'h08;
         3'h3: return 5'h0A;
         3'h4: return 5'h0C;
         3'h5: return 5'h10;
         3'h6: return 5'h14;
         3'h7: return 5'h18;
      endcase
   endfunction
   function automatic logic [15:0] justify(input logic [9:0] c, input logic ten,
                                           input logic right);
      logic [9:0] v;
      v = ten ? c : {2'h0, c[9:2]};
      if (right) begin
         return {6'h00, v};
      end
      return ten ? {v, 6'h00} : {v[7:0], 8'h00};
   endfunction
   // ------------------------------------------------------------
   // Conversion clock
   // ------------------------------------------------------------
   assign prs_write = BUS.wr && (BUS.addr == OFS_SAMPLE_PRS);
   conv_clk_div u_div (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .prescale (st_reg.smp_prs[PRS_LSB +: 5]),
      .reload   (prs_write),
      .tick     (tick)
   );
   assign seq_len = len_decode(st_reg.fmt[SEQ_LEN_LSB +: 4]);
   assign smp_len = smp_decode(st_reg.smp_prs[SMP_LSB +: 3]);
   assign abort   = prs_write || (BUS.wr && BUS.addr == OFS_SEQ_FORMAT);
   assign freeze_now = st_reg.break_s2 &&
                       (freeze_t'(st_reg.fmt[FREEZE_LSB +: 2]) == FRZ_NOW);
   assign freeze_end = st_reg.break_s2 &&
                       (freeze_t'(st_reg.fmt[FREEZE_LSB +: 2]) == FRZ_FINISH);
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.done     = 1'b0;
      st_next.break_s1 = DEBUG_BREAK;
      st_next.break_s2 = st_reg.break_s1;
      st_next.code_s1  = ANALOG_IN.code;
      st_next.code_s2  = st_reg.code_s1;
      st_next.ten_s1   = ANALOG_IN.ten_bit;
      st_next.ten_s2   = st_reg.ten_s1;
      st_next.rdata    = 8'h00;
      if (BUS.rd) begin
         unique case (BUS.addr)
            OFS_SEQ_FORMAT: st_next.rdata = st_reg.fmt;
            OFS_SAMPLE_PRS: st_next.rdata = st_reg.smp_prs;
            OFS_STATUS:     st_next.rdata = {4'h0, st_reg.conv_idx} |
                                            {st_reg.phase != S_IDLE, 7'h00};
            OFS_RESULT:     st_next.rdata = st_reg.result[15:8];
            default:        st_next.rdata = 8'h00;
         endcase
      end
      if (BUS.wr && BUS.addr == OFS_SEQ_FORMAT) begin
         st_next.fmt = BUS.wdata;
      end
      if (prs_write) begin
         st_next.smp_prs = BUS.wdata;
      end
      if (abort) begin
         st_next.phase     = S_IDLE;
         st_next.phase_cnt = 5'h00;
         st_next.conv_idx  = 4'h0;
      end else if (BUS.wr && BUS.addr == OFS_START) begin
         st_next.phase     = S_SAMPLE;
         st_next.phase_cnt = 5'h00;
         st_next.conv_idx  = 4'h0;
      end else begin
         unique case (st_reg.phase)
            S_IDLE: begin
               st_next.phase = S_IDLE;
            end
            S_SAMPLE: begin
               if (freeze_now) begin
                  st_next.phase = S_SAMPLE;
               end else if (tick) begin
                  if (st_reg.phase_cnt + 5'h01 >= smp_len) begin
                     st_next.phase     = S_CONV;
                     st_next.phase_cnt = 5'h00;
                  end else begin
                     st_next.phase_cnt = st_reg.phase_cnt + 5'h01;
                  end
               end
            end
            S_CONV: begin
               if (freeze_now) begin
                  st_next.phase = S_CONV;
               end else if (tick) begin
                  if (st_reg.phase_cnt + 5'h01 >= CONV_CYCLES) begin
                     st_next.phase_cnt = 5'h00;
                     st_next.result = justify(st_reg.code_s2, st_reg.ten_s2,
                                              st_reg.fmt[JUSTIFY_BIT]);
                     if (st_reg.conv_idx + 4'h1 >= seq_len) begin
                        st_next.phase    = S_IDLE;
                        st_next.conv_idx = 4'h0;
                        st_next.done     = 1'b1;
                     end else begin
                        st_next.conv_idx = st_reg.conv_idx + 4'h1;
                        st_next.phase    = freeze_end ? S_FROZEN : S_SAMPLE;
                     end
                  end else begin
                     st_next.phase_cnt = st_reg.phase_cnt + 5'h01;
                  end
               end
            end
            S_FROZEN: begin
               if (!freeze_end) begin
                  st_next.phase = S_SAMPLE;
               end
            end
            default: begin
               st_next.phase = S_IDLE;
            end
         endcase
      end
      st_next.active   = st_next.phase != S_IDLE;
      st_next.sampling = st_next.phase == S_SAMPLE;
   end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg         <= '0;
         st_reg.phase   <= S_IDLE;
         st_reg.fmt     <= SEQ_FORMAT_RST;
         st_reg.smp_prs <= SAMPLE_PRS_RST;
      end else begin
         st_reg <= st_next;
      end
   end
   assign RDATA      = st_reg.rdata;
   assign SEQ_ACTIVE = st_reg.active;
   assign SAMPLING   = st_reg.sampling;
   assign SEQ_DONE   = st_reg.done;
   assign RESULT     = st_reg.result;
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_len_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(RST_N) |-> st_reg.fmt[SEQ_LEN_LSB +: 4] == 4'h4)
      else $error("length code not four after reset");
   a_abort_prs: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      prs_write |=> !SEQ_ACTIVE)
      else $error("prescaler write did not abort");
   a_len_range: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      seq_len >= 4'h1 && seq_len <= SEQ_LEN_MAX)
      else $error("sequence length out of range");
   a_freeze_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (freeze_now && !abort && !(BUS.wr && BUS.addr == OFS_START) &&
       (SAMPLING || st_reg.phase == S_CONV)) |=> $stable(st_reg.phase_cnt))
      else $error("immediate freeze did not halt");
   a_finish_freeze: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.phase == S_FROZEN && freeze_end && !abort &&
       !(BUS.wr && BUS.addr == OFS_START)) |=> st_reg.phase == S_FROZEN)
      else $error("finish freeze left frozen state");
   a_smp_len: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.smp_prs[SMP_LSB +: 3] == 3'h7) |-> smp_len == 5'h18)
      else $error("sample length code 7 wrong");
   a_div_spacing: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (tick && st_reg.smp_prs[PRS_LSB +: 5] == 5'h00 && !prs_write)
      |=> !tick ##1 (tick || $past(prs_write)))
      else $error("divide by two spacing wrong");
   a_reload_tick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      prs_write |=> !tick)
      else $error("tick right after prescaler reload");
   a_right_just: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (SEQ_DONE && st_reg.fmt[JUSTIFY_BIT]) |-> RESULT[15:10] == 6'h00)
      else $error("right justified result has high bits");
   a_freeze_sel: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (BUS.wr && BUS.addr == OFS_SEQ_FORMAT) |=> st_reg.fmt[1:0] == $past(BUS.wdata[1:0]))
      else $error("freeze select not in bits 1..0");
   c_done: cover property (@(posedge CORE_CLK) disable iff (!RST_N) SEQ_DONE);
   c_frozen: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg.phase == S_FROZEN);
   c_abort: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      SEQ_ACTIVE && prs_write);
endmodule
`default_nettype wire

// ### test/adc_seq_ctrl_test.sv
`default_nettype none
module adc_seq_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_seq_pkg::*;
   // ---------------------------------------------
   // Signals and expectation tables
   // ---------------------------------------------
   localparam int SMP_TAB [8] = '{4, 6, 8, 10, 12, 16, 20, 24};
   localparam int FRZ_EXP [3] = '{56, 256, 238};
   logic        core_clk;
   logic        rst_n;
   logic        debug_break;
   bus_req_t    bus;
   analog_t     ana;
   logic [7:0]  rdata;
   logic        seq_active;
   logic        sampling;
   logic        seq_done;
   logic [15:0] result;
   logic [7:0]  rv;
   logic [1:0]  fz [3];
   int          bad_count, tests_run, seed, cyc, samp, n, sl, tk, p, s, c;

   adc_seq_ctrl u_adc_seq_ctrl (
      .CORE_CLK    (core_clk),
      .RST_N       (rst_n),
      .BUS         (bus),
      .RDATA       (rdata),
      .DEBUG_BREAK (debug_break),
      .ANALOG_IN   (ana),
      .SEQ_ACTIVE  (seq_active),
      .SAMPLING    (sampling),
      .SEQ_DONE    (seq_done),
      .RESULT      (result)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ---------------------------------------------
   // Bus, compare and sequence tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
      tests_run++;
      if (tol == 0 ? got !== exp : (got + tol < exp || got > exp + tol)) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Start a sequence, count cycles to done, pulse break in a cycle window
   task automatic run(input int bs, input int bl);
      reg_wr(OFS_START, 8'h00);
      cyc = 0;
      samp = 0;
      while (cyc < 20000) begin
         @(posedge core_clk);
         #1 cyc++;
         samp += (sampling === 1'b1);
         debug_break <= (cyc >= bs && cyc < bs + bl);
         if (seq_done === 1'b1) break;
      end
   endtask
   function automatic logic [15:0] res_exp(input logic [9:0] d, input logic t, input logic j);
      logic [9:0] v;
      v = t ? d : {2'h0, d[9:2]};
      if (j) return {6'h00, v};
      return t ? {v, 6'h00} : {v[7:0], 8'h00};
   endfunction
   task automatic stop_test;
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      seed = 71;
      bad_count = 0;
      tests_run = 0;
      rst_n = 1'b0;
      bus = '0;
      ana = '0;
      debug_break = 1'b0;
      fz = '{FRZ_CONTINUE, FRZ_NOW, FRZ_FINISH};
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      reg_rd(OFS_SEQ_FORMAT, rv);
      chk(rv, 8'h20, 0);
      reg_rd(OFS_SAMPLE_PRS, rv);
      chk(rv, 8'h00, 0);
      reg_rd(3'h0, rv);
      chk(rv, 8'h00, 0);
      // Every length code with random sample time and prescaler
      for (c = 0; c < 16; c++) begin
         s = $random(seed) & 7;
         p = $random(seed) & 1;
         reg_wr(OFS_SAMPLE_PRS, {s[2:0], p[4:0]});
         reg_wr(OFS_SEQ_FORMAT, {1'b1, c[3:0], 3'h0});
         reg_rd(OFS_SAMPLE_PRS, rv);
         chk(rv, {s[2:0], p[4:0]}, 0);
         run(0, 0);
         n = (c == 0 || c > 11) ? 12 : c;
         tk = 2 * (p + 1);
         sl = SMP_TAB[s];
         chk(cyc, n * (sl + 10) * tk, tk + 4);
         chk(samp, n * sl * tk, 2 * n + tk + 2);
      end
      // Breakpoint in each freeze mode, two conversions of 28 cycles
      reg_wr(OFS_SAMPLE_PRS, 8'h00);
      for (c = 0; c < 3; c++) begin
         reg_wr(OFS_SEQ_FORMAT, {1'b1, 4'h2, 1'b0, fz[c]});
         run(10, 200);
         chk(cyc, FRZ_EXP[c], 8);
      end
      // Writes to either control register abort a running sequence
      for (c = 0; c < 2; c++) begin
         reg_wr(OFS_START, 8'h00);
         repeat (20) @(posedge core_clk);
         reg_wr(c == 0 ? OFS_SAMPLE_PRS : OFS_SEQ_FORMAT, c == 0 ? 8'h00 : 8'hA0);
         #1 chk(seq_active, 1'b0, 0);
         n = 0;
         repeat (100) @(posedge core_clk) n += (seq_done === 1'b1 || seq_active !== 1'b0);
         chk(n, 0, 0);
      end
      // Result format: resolution, justification, full scale
      for (c = 0; c < 8; c++) begin
         ana <= '{code: c[2] ? 10'($random(seed)) : 10'h3FF, ten_bit: c[0]};
         reg_wr(OFS_SEQ_FORMAT, {c[1], 4'h1, 3'h0});
         run(0, 0);
         chk(result, res_exp(ana.code, c[0], c[1]), 0);
         reg_rd(OFS_RESULT, rv);
         chk(rv, res_exp(ana.code, c[0], c[1]) >> 8, 0);
      end
      stop_test;
   end

   initial begin
      repeat (80000) @(posedge core_clk);
      bad_count++;
      stop_test;
   end
endmodule
`default_nettype wire
